//--- pkg/canopen_adapter_pkg.sv
package canopen_adapter_pkg;

    // Image sizes
    localparam int BASE_IO = 24;
    localparam int MAX_IO = 128;
    localparam int STATUS_BYTE = 3;

    // Status byte bit positions
    localparam int ST_OUT_FAULT = 0;
    localparam int ST_IN_FAULT = 1;
    localparam int ST_GEN_FAULT = 2;
    localparam int ST_SERVICE = 3;
    localparam int ST_RUNNING = 4;
    localparam int ST_EXCHANGE = 5;

    // Start-up settle time, lets the pin synchronisers fill
    localparam int SETTLE_NS = 1000;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Selector positions
    localparam logic [3:0] SEL_MAX_DIGIT = 4'h9;
    localparam logic [3:0] RATE_POS_NONE_LO = 4'h0;
    localparam logic [3:0] RATE_POS_NONE_HI = 4'h9;

    // Bit rate in kbit/s per selector position
    localparam logic [9:0] KBPS_10 = 10'h00A;
    localparam logic [9:0] KBPS_20 = 10'h014;
    localparam logic [9:0] KBPS_50 = 10'h032;
    localparam logic [9:0] KBPS_125 = 10'h07D;
    localparam logic [9:0] KBPS_250 = 10'h0FA;
    localparam logic [9:0] KBPS_500 = 10'h1F4;
    localparam logic [9:0] KBPS_800 = 10'h320;
    localparam logic [9:0] KBPS_1000 = 10'h3E8;
    localparam logic [9:0] KBPS_NONE = 10'h000;

    localparam logic [6:0] TENS_WEIGHT = 7'h0A;

    typedef enum logic [3:0] {
        ST_SETTLE = 4'b0001,
        ST_SAMPLE = 4'b0010,
        ST_RUN = 4'b0100,
        ST_FAULT = 4'b1000
    } adapter_state_t;

endpackage

//--- pkg/startup_cfg_if.sv
`timescale 1ns/1ps
`default_nettype none
interface startup_cfg_if;
    logic sample;
    logic [3:0] rate_sel;
    logic [3:0] tens_sel;
    logic [3:0] ones_sel;
    logic done;
    logic rate_ok;
    logic addr_ok;
    logic [3:0] rate_pos;
    logic [9:0] kbps;
    logic [6:0] station;

    modport ctl (
        output sample, rate_sel, tens_sel, ones_sel,
        input done, rate_ok, addr_ok, rate_pos, kbps, station
    );
    modport dec (
        input sample, rate_sel, tens_sel, ones_sel,
        output done, rate_ok, addr_ok, rate_pos, kbps, station
    );
endinterface
`default_nettype wire

//--- hw/selector_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module selector_decoder
    import canopen_adapter_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    startup_cfg_if.dec cfg
);

    logic [9:0] dec_kbps;
    logic dec_rate_ok;
    logic dec_addr_ok;
    logic [6:0] dec_station;

    always_comb begin
        dec_kbps = KBPS_NONE;
        unique case (cfg.rate_sel)
            4'h1: dec_kbps = KBPS_10;
            4'h2: dec_kbps = KBPS_20;
            4'h3: dec_kbps = KBPS_50;
            4'h4: dec_kbps = KBPS_125;
            4'h5: dec_kbps = KBPS_250;
            4'h6: dec_kbps = KBPS_500;
            4'h7: dec_kbps = KBPS_800;
            4'h8: dec_kbps = KBPS_1000;
            default: dec_kbps = KBPS_NONE;
        endcase
    end

    assign dec_rate_ok = (cfg.rate_sel != RATE_POS_NONE_LO) && (cfg.rate_sel < RATE_POS_NONE_HI);
    assign dec_addr_ok = (cfg.tens_sel <= SEL_MAX_DIGIT) && (cfg.ones_sel <= SEL_MAX_DIGIT);
    assign dec_station = 7'(cfg.tens_sel * TENS_WEIGHT) + {3'h0, cfg.ones_sel};

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            cfg.done <= 1'b0;
            cfg.rate_ok <= 1'b0;
            cfg.addr_ok <= 1'b0;
            cfg.rate_pos <= 4'h0;
            cfg.kbps <= KBPS_NONE;
            cfg.station <= 7'h00;
        end else if (i_ce && cfg.sample) begin
            cfg.done <= 1'b1;
            cfg.rate_ok <= dec_rate_ok;
            cfg.addr_ok <= dec_addr_ok;
            cfg.rate_pos <= cfg.rate_sel;
            cfg.kbps <= dec_kbps;
            cfg.station <= dec_addr_ok ? dec_station : 7'h00;
        end
    end

endmodule // selector_decoder
`default_nettype wire

//--- hw/canopen_slave_io_image_adapter.sv
`timescale 1ns/1ps
`default_nettype none
module canopen_slave_io_image_adapter
    import canopen_adapter_pkg::*;
#(
    parameter int NUM_IO = BASE_IO
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_bit_rate_selector,
    input wire logic [3:0] i_address_tens_selector,
    input wire logic [3:0] i_address_ones_selector,
    input wire logic [NUM_IO-1:0] i_virtual_output_bit,
    input wire logic i_output_error_lamp,
    input wire logic i_input_error_lamp,
    input wire logic i_general_error_lamp,
    input wire logic i_service_notice_lamp,
    input wire logic i_running_lamp,
    input wire logic i_rx_valid,
    input wire logic [4:0] i_rx_byte_index,
    input wire logic [7:0] i_rx_data,
    input wire logic i_exchange_active,
    input wire logic i_bus_error,
    output logic [NUM_IO-1:0] o_virtual_input_bit,
    output logic o_input_update,
    output logic [(NUM_IO/8+1)*8-1:0] o_tx_image,
    output logic o_bus_enable,
    output logic [3:0] o_bit_rate_position,
    output logic [9:0] o_bit_rate_kbps,
    output logic [6:0] o_station_address,
    output logic o_led_power,
    output logic o_led_run,
    output logic o_led_error
);

    localparam int IN_BYTES = NUM_IO / 8;
    localparam int TX_BYTES = NUM_IO / 8 + 1;
    localparam logic [4:0] IN_BYTES_W = 5'(IN_BYTES);
    localparam logic [$clog2(SETTLE_CYCLES+1)-1:0] SETTLE_LAST =
        ($clog2(SETTLE_CYCLES+1))'(SETTLE_CYCLES - 1);

    initial begin
        if (NUM_IO < BASE_IO || NUM_IO > MAX_IO || (NUM_IO % 8) != 0) begin
            $error("NUM_IO must be a multiple of 8 from 24 to 128");
        end
    end

    // Source byte of transmitted byte t; byte 3 is status, so
    // outputs 24 and up move one byte further out.
    function automatic int tx_src_byte(input int t);
        if (t < STATUS_BYTE) begin
            return t;
        end
        return t - 1;
    endfunction

    // Pin synchronisers
    logic [3:0] rate_meta;
    logic [3:0] rate_sync;
    logic [3:0] tens_meta;
    logic [3:0] tens_sync;
    logic [3:0] ones_meta;
    logic [3:0] ones_sync;

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rate_meta <= 4'h0;
            rate_sync <= 4'h0;
            tens_meta <= 4'h0;
            tens_sync <= 4'h0;
            ones_meta <= 4'h0;
            ones_sync <= 4'h0;
        end else if (i_ce) begin
            rate_meta <= i_bit_rate_selector;
            rate_sync <= rate_meta;
            tens_meta <= i_address_tens_selector;
            tens_sync <= tens_meta;
            ones_meta <= i_address_ones_selector;
            ones_sync <= ones_meta;
        end
    end

    startup_cfg_if cfg ();

    assign cfg.rate_sel = rate_sync;
    assign cfg.tens_sel = tens_sync;
    assign cfg.ones_sel = ones_sync;

    selector_decoder u_decoder (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .cfg(cfg)
    );

    // Start-up sequencer
    adapter_state_t state;
    adapter_state_t next_state;
    logic [$clog2(SETTLE_CYCLES+1)-1:0] settle_cnt;
    logic settle_done;
    logic sample;
    logic cfg_good;

    assign settle_done = (settle_cnt == SETTLE_LAST);
    assign cfg_good = cfg.rate_ok && cfg.addr_ok;
    assign cfg.sample = sample;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_SETTLE: begin
                if (settle_done) begin
                    next_state = ST_SAMPLE;
                end
            end
            ST_SAMPLE: begin
                if (cfg.done) begin
                    next_state = cfg_good ? ST_RUN : ST_FAULT;
                end
            end
            ST_RUN: next_state = ST_RUN;
            ST_FAULT: next_state = ST_FAULT;
            default: next_state = ST_FAULT;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state <= ST_SETTLE;
            settle_cnt <= '0;
            sample <= 1'b0;
        end else if (i_ce) begin
            state <= next_state;
            sample <= (state == ST_SETTLE) && settle_done;
            if (state == ST_SETTLE && !settle_done) begin
                settle_cnt <= settle_cnt + 1'b1;
            end
        end
    end

    // Configuration outputs; fixed once sampled
    logic running;
    assign running = (state == ST_RUN);

    // off the bus on bad rate
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_bus_enable <= 1'b0;
            o_bit_rate_position <= 4'h0;
            o_bit_rate_kbps <= KBPS_NONE;
            o_station_address <= 7'h00;
        end else if (i_ce) begin
            o_bus_enable <= (next_state == ST_RUN);
            o_bit_rate_position <= cfg.rate_pos;
            o_bit_rate_kbps <= cfg.rate_ok ? cfg.kbps : KBPS_NONE;
            o_station_address <= cfg.station;
        end
    end

    // Receive path: writes one input byte at a time
    logic rx_take;
    assign rx_take = i_rx_valid && running && (i_rx_byte_index < IN_BYTES_W);

    genvar gb;
    generate
        for (gb = 0; gb < IN_BYTES; gb++) begin : g_in_byte
            logic hit;
            assign hit = rx_take && (i_rx_byte_index == 5'(gb));
            // byte b bit k to input 8b+k
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    o_virtual_input_bit[gb*8 +: 8] <= 8'h00;
                end else if (i_ce && hit) begin
                    o_virtual_input_bit[gb*8 +: 8] <= i_rx_data;
                end
            end
        end
    endgenerate

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_input_update <= 1'b0;
        end else if (i_ce) begin
            o_input_update <= rx_take;
        end
    end

    // Transmit path
    logic exchanging;
    logic [7:0] status_byte;

    assign exchanging = running && i_exchange_active;

    always_comb begin
        status_byte = 8'h00;
        status_byte[ST_OUT_FAULT] = i_output_error_lamp;
        status_byte[ST_IN_FAULT] = i_input_error_lamp;
        status_byte[ST_GEN_FAULT] = i_general_error_lamp;
        status_byte[ST_SERVICE] = i_service_notice_lamp;
        status_byte[ST_RUNNING] = i_running_lamp;
        status_byte[ST_EXCHANGE] = exchanging;
    end

    genvar gt;
    generate
        for (gt = 0; gt < TX_BYTES; gt++) begin : g_tx_byte
            logic [7:0] next_byte;
            if (gt == STATUS_BYTE) begin : g_status
                assign next_byte = status_byte;
            end else begin : g_data
                assign next_byte = i_virtual_output_bit[tx_src_byte(gt)*8 +: 8];
            end
            always_ff @(posedge i_mclk) begin
                if (i_rst) begin
                    o_tx_image[gt*8 +: 8] <= 8'h00;
                end else if (i_ce) begin
                    o_tx_image[gt*8 +: 8] <= next_byte;
                end
            end
        end
    endgenerate

    // single adapter assumed; no arbitration here
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            o_led_power <= 1'b1;
            o_led_run <= 1'b0;
            o_led_error <= 1'b0;
        end else if (i_ce) begin
            o_led_power <= 1'b1;
            o_led_run <= running;
            o_led_error <= (state == ST_FAULT) || (running && i_bus_error);
        end
    end

endmodule // canopen_slave_io_image_adapter
`default_nettype wire

//--- bench/adapter_chk.sv
`timescale 1ns/1ps
`default_nettype none
module adapter_chk #(
    parameter int NUM_IO = 24
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_rx_valid,
    input wire logic [4:0] i_rx_byte_index,
    input wire logic [7:0] i_rx_data,
    input wire logic [NUM_IO-1:0] i_virtual_output_bit,
    input wire logic i_output_error_lamp,
    input wire logic i_input_error_lamp,
    input wire logic i_general_error_lamp,
    input wire logic i_service_notice_lamp,
    input wire logic i_running_lamp,
    input wire logic i_exchange_active,
    input wire logic i_bus_error,
    input wire logic [NUM_IO-1:0] o_virtual_input_bit,
    input wire logic o_input_update,
    input wire logic [(NUM_IO/8+1)*8-1:0] o_tx_image,
    input wire logic o_bus_enable,
    input wire logic [9:0] o_bit_rate_kbps,
    input wire logic [6:0] o_station_address,
    input wire logic o_led_power,
    input wire logic o_led_run,
    input wire logic o_led_error
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);
    rx_take_a: assert property (
        i_ce && i_rx_valid && o_led_run && i_rx_byte_index < NUM_IO/8 |=> o_input_update &&
        o_virtual_input_bit[8*$past(i_rx_byte_index)+:8] == $past(i_rx_data)) else $error("rx byte lost");
    rx_ignore_a: assert property (
        !(i_rx_valid && i_rx_byte_index < NUM_IO/8) |=> !o_input_update && $stable(o_virtual_input_bit))
        else $error("rx image changed");
    tx_map_a: assert property (
        i_ce |=> o_tx_image[23:0] == $past(i_virtual_output_bit[23:0])) else $error("tx image wrong");
    lamp_bits_a: assert property (
        i_ce |=> o_tx_image[28:24] == $past({i_running_lamp, i_service_notice_lamp, i_general_error_lamp,
        i_input_error_lamp, i_output_error_lamp})) else $error("lamp bits wrong");
    exch_set_a: assert property (
        i_ce && o_led_run && i_exchange_active |=> o_tx_image[29]) else $error("exchange bit low");
    exch_clr_a: assert property (
        i_ce && !i_exchange_active |=> o_tx_image[31:29] == 3'h0) else $error("exchange bit high");
    off_bus_a: assert property (
        o_bit_rate_kbps == 10'h000 |-> !o_bus_enable && !o_led_run) else $error("on bus without rate");
    addr_max_a: assert property (o_station_address <= 7'h63) else $error("station above 99");
    start_up_a: assert property (
        $fell(i_rst) |-> ##[98:110] (o_led_run || o_led_error)) else $error("no start");
    cfg_hold_a: assert property (
        o_bus_enable |=> $stable(o_station_address) && $stable(o_bit_rate_kbps)) else $error("cfg moved");
    run_led_a: assert property (o_led_run == $past(o_bus_enable) && o_led_power) else $error("led wrong");
    bus_err_a: assert property (
        i_ce && o_led_run && i_bus_error |=> o_led_error) else $error("error led low");
endmodule // adapter_chk
`default_nettype wire

//--- bench/canopen_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module canopen_master_model (
    input wire logic i_mclk,
    output logic o_rx_valid,
    output logic [4:0] o_rx_byte_index,
    output logic [7:0] o_rx_data,
    output logic o_exchange_active,
    output logic o_bus_error
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_byte_index = 5'h1F;
        o_rx_data = 8'h00;
        o_exchange_active = 1'b0;
        o_bus_error = 1'b0;
    end
    task automatic send(input logic [4:0] idx, input logic [7:0] dat, input logic last);
        o_rx_valid = 1'b1;
        o_rx_byte_index = idx;
        o_rx_data = dat;
        @(posedge i_mclk);
        #1;
        // Idle lines invert so stale data cannot pass
        if (last) begin
            o_rx_valid = 1'b0;
            o_rx_data = ~dat;
            o_rx_byte_index = ~idx;
        end
    endtask
    task automatic link(input logic ex, input logic er);
        o_exchange_active = ex;
        o_bus_error = er;
    endtask
endmodule // canopen_master_model
`default_nettype wire

//--- bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk, rst, ce, rxv, exch, berr, upd, bus_en, pwr, run, lerr;
    logic [3:0] rsel, tsel, osel, rpos;
    logic [23:0] vout, vin;
    logic [4:0] lamps, ridx;
    logic [7:0] rdat;
    logic [31:0] tx;
    logic [9:0] kbps;
    logic [6:0] stn;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    logic [9:0] kb_tab [10] = '{10'h000, 10'h00A, 10'h014, 10'h032, 10'h07D, 10'h0FA, 10'h1F4, 10'h320,
        10'h3E8, 10'h000};
    canopen_slave_io_image_adapter dut (
        .i_mclk(clk), .i_rst(rst), .i_ce(ce), .i_bit_rate_selector(rsel),
        .i_address_tens_selector(tsel), .i_address_ones_selector(osel), .i_virtual_output_bit(vout),
        .i_output_error_lamp(lamps[0]), .i_input_error_lamp(lamps[1]), .i_general_error_lamp(lamps[2]),
        .i_service_notice_lamp(lamps[3]), .i_running_lamp(lamps[4]), .i_rx_valid(rxv),
        .i_rx_byte_index(ridx), .i_rx_data(rdat), .i_exchange_active(exch), .i_bus_error(berr),
        .o_virtual_input_bit(vin), .o_input_update(upd), .o_tx_image(tx), .o_bus_enable(bus_en),
        .o_bit_rate_position(rpos), .o_bit_rate_kbps(kbps), .o_station_address(stn),
        .o_led_power(pwr), .o_led_run(run), .o_led_error(lerr)
    );
    canopen_master_model master (
        .i_mclk(clk), .o_rx_valid(rxv), .o_rx_byte_index(ridx), .o_rx_data(rdat),
        .o_exchange_active(exch), .o_bus_error(berr)
    );
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Ceiling well above about 1900 cycles of tests
    initial begin
        forever begin
            @(posedge clk);
            cycles++;
            if (cycles == 6000) begin
                err_total++;
                test_done();
            end
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic start(input logic [3:0] r, input logic [3:0] t, input logic [3:0] o);
        rsel = r;
        tsel = t;
        osel = o;
        rst = 1'b1;
        tick(5);
        rst = 1'b0;
        for (int k = 0; k < 200 && run !== 1'b1 && lerr !== 1'b1; k++) tick(1);
        tick(1);
    endtask
    task automatic t_rates();
        for (int p = 0; p < 10; p++) begin
            start(p[3:0], 4'h3, 4'h6);
            chk(kbps, kb_tab[p]);
            chk(rpos, p);
            chk(bus_en, 32'(p > 0 && p < 9));
            chk(lerr, 32'(p == 0 || p == 9));
        end
    endtask
    task automatic t_addr();
        logic [3:0] tn [3] = '{4'h3, 4'h9, 4'h0};
        logic [3:0] on [3] = '{4'h6, 4'h9, 4'h0};
        for (int i = 0; i < 3; i++) begin
            start(4'h4, tn[i], on[i]);
            chk(stn, 10 * tn[i] + on[i]);
        end
        start(4'h4, 4'hA, 4'h2);
        chk(bus_en, 0);
        start(4'h4, 4'h3, 4'h6);
        rsel = 4'h7;
        tsel = 4'h1;
        osel = 4'h2;
        tick(150);
        chk(stn, 36);
        chk(kbps, 125);
    endtask
    task automatic t_rx();
        start(4'h8, 4'h1, 4'h2);
        master.send(5'h01, 8'h10, 1'b1);
        chk(upd, 1);
        chk(vin[12], 1);
        tick(1);
        chk(upd, 0);
        master.send(5'h00, 8'hA5, 1'b0);
        master.send(5'h02, 8'h3C, 1'b0);
        chk(vin, 24'h3C10A5);
        master.send(5'h03, 8'hFF, 1'b1);
        chk(upd, 0);
        chk(vin, 24'h3C10A5);
    endtask
    task automatic t_tx();
        vout = 24'h5A0F21;
        master.link(1'b1, 1'b0);
        for (int i = 0; i < 5; i++) begin
            lamps = 5'h01 << i;
            tick(1);
            chk(tx[28:24], 5'h01 << i);
        end
        chk(tx[23:0], 24'h5A0F21);
        chk(tx[31:29], 3'h1);
        master.link(1'b0, 1'b1);
        tick(2);
        chk(tx[31:29], 3'h0);
        chk(lerr, 1);
        chk(pwr, 1);
        master.link(1'b0, 1'b0);
        tick(2);
        chk(lerr, 0);
    endtask
    // Enable low must freeze both images
    task automatic t_ce();
        ce = 1'b0;
        vout = 24'h123456;
        master.send(5'h00, 8'h77, 1'b1);
        tick(2);
        chk(tx[23:0], 24'h5A0F21);
        chk(vin, 24'h3C10A5);
        chk(upd, 0);
        ce = 1'b1;
        tick(1);
        chk(tx[23:0], 24'h123456);
        chk(vin, 24'h3C10A5);
    endtask
    initial begin
        rst = 1'b1;
        rsel = 4'h0;
        tsel = 4'h0;
        osel = 4'h0;
        vout = 24'h000000;
        lamps = 5'h00;
        ce = 1'b1;
        #1;
        t_rates();
        t_addr();
        t_rx();
        t_tx();
        t_ce();
        test_done();
    end
endmodule // tb
bind canopen_slave_io_image_adapter adapter_chk #(.NUM_IO(NUM_IO)) chk_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_ce(i_ce), .i_rx_valid(i_rx_valid),
    .i_rx_byte_index(i_rx_byte_index), .i_rx_data(i_rx_data), .i_virtual_output_bit(i_virtual_output_bit),
    .i_output_error_lamp(i_output_error_lamp), .i_input_error_lamp(i_input_error_lamp),
    .i_general_error_lamp(i_general_error_lamp), .i_service_notice_lamp(i_service_notice_lamp),
    .i_running_lamp(i_running_lamp), .i_exchange_active(i_exchange_active), .i_bus_error(i_bus_error),
    .o_virtual_input_bit(o_virtual_input_bit), .o_input_update(o_input_update), .o_tx_image(o_tx_image),
    .o_bus_enable(o_bus_enable), .o_bit_rate_kbps(o_bit_rate_kbps), .o_station_address(o_station_address),
    .o_led_power(o_led_power), .o_led_run(o_led_run), .o_led_error(o_led_error)
);
`default_nettype wire
